/* File: hw/bit_timer.sv */
`timescale 1ns/1ps
module bit_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  input wire logic sc_sel,
  output logic bit_end,
  output logic [1:0] quarter,
  output logic subcarrier
);
  typedef struct packed {
    logic [9:0] cnt;
    logic [1:0] quarter;
    logic [6:0] sc_cnt;
    logic sc;
    logic [11:0] gap;
    logic seen;
  } timer_state_t;
  timer_state_t s;
  timer_state_t next_s;
  logic [9:0] limit;
  logic [6:0] sc_limit;
  logic q_end;

  always_comb begin
    case (rate_sel)
      3'h3: limit = tx_enc_pkg::QUARTER_53;
      3'h4: limit = tx_enc_pkg::QUARTER_106;
      3'h5: limit = tx_enc_pkg::QUARTER_212;
      3'h6: limit = tx_enc_pkg::QUARTER_424;
      3'h7: limit = tx_enc_pkg::QUARTER_848;
      default: limit = tx_enc_pkg::QUARTER_26;
    endcase
  end

  // subcarrier half period
  assign sc_limit = sc_sel ? tx_enc_pkg::SC_HALF_848
                           : tx_enc_pkg::SC_HALF_424;
  assign q_end = s.cnt == limit - 10'd1;
  assign bit_end = run && q_end && s.quarter == 2'd3;
  assign quarter = s.quarter;
  assign subcarrier = s.sc;

  always_comb begin
    next_s = s;
    if (!run) begin
      next_s.cnt = 10'h000;
      next_s.quarter = 2'h0;
    end else if (q_end) begin
      next_s.cnt = 10'h000;
      next_s.quarter = s.quarter + 2'd1;
    end else begin
      next_s.cnt = s.cnt + 10'd1;
    end
    if (s.sc_cnt >= sc_limit - 7'd1) begin
      next_s.sc_cnt = 7'h00;
      next_s.sc = ~s.sc;
    end else begin
      next_s.sc_cnt = s.sc_cnt + 7'd1;
    end
    if (!run) begin
      next_s.seen = 1'b0;
      next_s.gap = 12'h000;
    end else if (bit_end) begin
      next_s.seen = 1'b1;
      next_s.gap = 12'h000;
    end else begin
      next_s.gap = s.gap + 12'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  bit_period_a: assert property (@(posedge clk) disable iff (reset)
    bit_end && s.seen |-> s.gap == 12'({limit, 2'b00} - 12'd1))
    else $error("bit period does not match bit rate");
endmodule : bit_timer

/* File: hw/envelope_shaper.sv */
`timescale 1ns/1ps
module envelope_shaper (
  input wire logic bit_val,
  input wire logic prev_bit,
  input wire logic [1:0] quarter,
  input wire logic [1:0] pulse_kind,
  input wire logic miller,
  input wire logic [2:0] env_kind,
  input wire logic invert,
  input wire logic subcarrier,
  output logic level
);
  logic pulsed;
  logic manch;
  logic env;

  always_comb begin
    pulsed = bit_val;
    if (miller) begin
      // one: pulse in third quarter; zero after zero: pulse at start
      if (bit_val) begin
        pulsed = quarter == 2'd2;
      end else begin
        pulsed = !prev_bit && quarter == 2'd0;
      end
    end else begin
      case (pulse_kind)
        tx_enc_pkg::PULSE_START: pulsed = bit_val && quarter == 2'd0;
        tx_enc_pkg::PULSE_HALF: pulsed = bit_val && quarter[1];
        tx_enc_pkg::PULSE_QUARTER3: pulsed = bit_val && quarter == 2'd2;
        default: pulsed = bit_val;
      endcase
    end
    manch = quarter[1] ? ~pulsed : pulsed;
    // subcarrier only reaches the output in the ENV_MANCH_SC and ENV_BPSK envelopes
    case (env_kind)
      tx_enc_pkg::ENV_MANCH: env = manch;
      tx_enc_pkg::ENV_MANCH_SC: env = manch & subcarrier;
      tx_enc_pkg::ENV_BPSK: env = pulsed ^ subcarrier;
      default: env = pulsed;
    endcase
    level = env ^ invert;
  end
endmodule : envelope_shaper

/* File: hw/tx_bit_framing_encoder.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module tx_bit_framing_encoder (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_envelope,
  output logic tx_frame,
  output logic tx_busy
);
  typedef struct packed {
    logic [7:0] bit_framing;
    logic [7:0] data_coding;
    logic [7:0] data_mod;
    logic [7:0] frame_opt;
    logic [7:0] rdata;
    tx_enc_pkg::tx_state_t state;
    logic [7:0] byte_buf;
    logic last;
    logic [2:0] idx;
    logic [7:0] slot;
    logic [1:0] sym;
    logic [1:0] unit;
    logic prev_bit;
    logic ready;
    logic frame;
    logic busy;
    logic env;
  } enc_state_t;
  enc_state_t s;
  enc_state_t next_s;

  logic [3:0] code;
  logic high_order;
  logic parity_odd;
  logic stop_level;
  logic start_level;
  logic start_enable;
  logic frame_step;
  logic parity_en;
  logic stop_en;
  logic bit_end;
  logic [1:0] quarter;
  logic subcarrier;
  logic shaped;
  logic run;
  logic accept;
  logic bit_state;
  logic slot_code;
  logic is_pie;
  logic is_rz;
  logic data_bit;
  logic parity_bit;
  logic cur_bit;
  logic pseudo;
  logic adv;
  logic [1:0] pie_last;
  logic [7:0] pair_lsb;
  logic [7:0] pair_msb;
  logic [7:0] slot_target;
  logic [7:0] slot_last;
  tx_enc_pkg::tx_state_t first_state;
  tx_enc_pkg::tx_state_t end_state;

  assign code = s.data_coding[tx_enc_pkg::CODE_SEL_POS +: 4];
  assign high_order = s.bit_framing[tx_enc_pkg::HIGH_ORDER_POS];
  assign parity_odd = s.bit_framing[tx_enc_pkg::PARITY_ODD_POS];
  assign stop_level = s.bit_framing[tx_enc_pkg::STOP_LEVEL_POS];
  assign start_level = s.bit_framing[tx_enc_pkg::START_LEVEL_POS];
  assign start_enable = s.bit_framing[tx_enc_pkg::START_ENABLE_POS];
  assign frame_step = s.data_mod[tx_enc_pkg::FRAME_STEP_POS];
  assign parity_en = s.frame_opt[tx_enc_pkg::PARITY_EN_POS];
  assign stop_en = s.frame_opt[tx_enc_pkg::STOP_EN_POS];

  bit_timer u_timer (
    .clk(clk),
    .reset(reset),
    .run(run),
    .rate_sel(s.data_coding[tx_enc_pkg::BIT_RATE_POS +: 3]),
    .sc_sel(s.data_coding[tx_enc_pkg::SUBCARRIER_POS]),
    .bit_end(bit_end),
    .quarter(quarter),
    .subcarrier(subcarrier)
  );

  envelope_shaper u_shaper (
    .bit_val(pseudo),
    .prev_bit(s.prev_bit),
    .quarter(quarter),
    .pulse_kind(s.data_mod[tx_enc_pkg::PULSE_KIND_POS +: 2]),
    .miller(s.data_mod[tx_enc_pkg::MILLER_POS]),
    .env_kind(s.data_mod[tx_enc_pkg::ENV_KIND_POS +: 3]),
    .invert(s.data_mod[tx_enc_pkg::INVERT_POS]),
    .subcarrier(subcarrier),
    .level(shaped)
  );

  // symbol source
  assign run = s.state != tx_enc_pkg::ST_IDLE
            && s.state != tx_enc_pkg::ST_NEXT;
  assign accept = s.ready && tx_valid;
  assign bit_state = s.state == tx_enc_pkg::ST_START
                  || s.state == tx_enc_pkg::ST_DATA
                  || s.state == tx_enc_pkg::ST_PARITY
                  || s.state == tx_enc_pkg::ST_STOP;
  assign slot_code = code >= tx_enc_pkg::CODE_ONE_OF_4
                  && code <= tx_enc_pkg::CODE_256_ZERO_LAST;
  assign is_pie = code == tx_enc_pkg::CODE_PIE;
  assign is_rz = code >= tx_enc_pkg::CODE_RZ_FIRST
              && code <= tx_enc_pkg::CODE_RZ_LAST;
  assign data_bit = high_order ? s.byte_buf[3'd7 - s.idx]
                               : s.byte_buf[s.idx];
  assign parity_bit = (^s.byte_buf) ^ parity_odd;

  always_comb begin
    case (s.state)
      tx_enc_pkg::ST_START: cur_bit = start_level;
      tx_enc_pkg::ST_DATA: cur_bit = data_bit;
      tx_enc_pkg::ST_PARITY: cur_bit = parity_bit;
      tx_enc_pkg::ST_STOP: cur_bit = stop_level;
      default: cur_bit = 1'b0;
    endcase
  end

  // slot codes: one-of-four pairs or one-of-256 bytes
  assign pair_lsb = s.byte_buf >> {s.sym, 1'b0};
  assign pair_msb = s.byte_buf >> (3'd6 - {s.sym, 1'b0});
  assign slot_last = (code == tx_enc_pkg::CODE_ONE_OF_4)
                   ? tx_enc_pkg::SLOT_LAST_4 : tx_enc_pkg::SLOT_LAST_256;
  always_comb begin
    if (code == tx_enc_pkg::CODE_ONE_OF_4) begin
      slot_target = {6'h00, high_order ? pair_msb[1:0]
                                       : pair_lsb[1:0]};
    end else if (code == tx_enc_pkg::CODE_256_ZERO_LAST
                 && s.byte_buf == 8'h00) begin
      slot_target = tx_enc_pkg::SLOT_LAST_256;
    end else begin
      slot_target = s.byte_buf;
    end
  end

  assign pie_last = cur_bit ? tx_enc_pkg::PIE_ONE_LAST
                            : tx_enc_pkg::PIE_ZERO_LAST;

  always_comb begin
    if (s.state == tx_enc_pkg::ST_SLOTS) begin
      pseudo = s.slot == slot_target
            && !(code == tx_enc_pkg::CODE_256_ZERO_NONE
                 && s.byte_buf == 8'h00);
    end else if (bit_state && is_pie) begin
      pseudo = s.unit == pie_last;
    end else if (bit_state && is_rz) begin
      pseudo = cur_bit && quarter == code[1:0];
    end else begin
      pseudo = bit_state && cur_bit;
    end
  end

  // pie symbols span two or four bit periods
  assign adv = bit_end
            && (!(is_pie && bit_state) || s.unit == pie_last);

  always_comb begin
    if (slot_code) begin
      first_state = tx_enc_pkg::ST_SLOTS;
    end else if (start_enable) begin
      first_state = tx_enc_pkg::ST_START;
    end else begin
      first_state = tx_enc_pkg::ST_DATA;
    end
    if (s.last) begin
      end_state = tx_enc_pkg::ST_IDLE;
    end else if (frame_step) begin
      end_state = tx_enc_pkg::ST_GAP;
    end else begin
      end_state = tx_enc_pkg::ST_NEXT;
    end
  end

  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    if (wr) begin
      if (addr == tx_enc_pkg::ADDR_BIT_FRAMING) begin
        next_s.bit_framing = wdata & tx_enc_pkg::BIT_FRAMING_MASK;
      end else if (addr == tx_enc_pkg::ADDR_DATA_CODING) begin
        next_s.data_coding = wdata;
      end else if (addr == tx_enc_pkg::ADDR_DATA_MOD) begin
        next_s.data_mod = wdata;
      end else if (addr == tx_enc_pkg::ADDR_FRAME_OPT) begin
        next_s.frame_opt = wdata & tx_enc_pkg::FRAME_OPT_MASK;
      end
    end
    if (rd) begin
      if (addr == tx_enc_pkg::ADDR_BIT_FRAMING) begin
        next_s.rdata = s.bit_framing;
      end else if (addr == tx_enc_pkg::ADDR_DATA_CODING) begin
        next_s.rdata = s.data_coding;
      end else if (addr == tx_enc_pkg::ADDR_DATA_MOD) begin
        next_s.rdata = s.data_mod;
      end else if (addr == tx_enc_pkg::ADDR_FRAME_OPT) begin
        next_s.rdata = s.frame_opt;
      end else if (addr == tx_enc_pkg::ADDR_STATUS) begin
        next_s.rdata[tx_enc_pkg::BUSY_POS] = s.busy;
        next_s.rdata[tx_enc_pkg::FRAME_POS] = s.frame;
        next_s.rdata[tx_enc_pkg::READY_POS] = s.ready;
      end
    end
    if (bit_state) begin
      next_s.unit = bit_end ? (adv ? 2'h0 : s.unit + 2'd1) : s.unit;
    end
    if (bit_state && adv) begin
      next_s.prev_bit = cur_bit;
    end
    case (s.state)
      tx_enc_pkg::ST_IDLE, tx_enc_pkg::ST_NEXT: begin
        if (accept) begin
          next_s.byte_buf = tx_data;
          next_s.last = tx_last;
          next_s.idx = 3'h0;
          next_s.slot = 8'h00;
          next_s.sym = 2'h0;
          next_s.unit = 2'h0;
          next_s.prev_bit = s.prev_bit && !frame_step
                         && s.state == tx_enc_pkg::ST_NEXT;
          next_s.state = first_state;
        end
      end
      tx_enc_pkg::ST_START: begin
        if (adv) begin
          next_s.state = tx_enc_pkg::ST_DATA;
        end
      end
      tx_enc_pkg::ST_DATA: begin
        if (adv) begin
          next_s.idx = s.idx + 3'd1;
          if (s.idx == 3'd7) begin
            if (parity_en) begin
              next_s.state = tx_enc_pkg::ST_PARITY;
            end else if (stop_en) begin
              next_s.state = tx_enc_pkg::ST_STOP;
            end else begin
              next_s.state = end_state;
            end
          end
        end
      end
      tx_enc_pkg::ST_PARITY: begin
        if (adv) begin
          next_s.state = stop_en ? tx_enc_pkg::ST_STOP : end_state;
        end
      end
      tx_enc_pkg::ST_STOP: begin
        if (adv) begin
          next_s.state = end_state;
        end
      end
      tx_enc_pkg::ST_SLOTS: begin
        if (bit_end) begin
          next_s.slot = s.slot + 8'd1;
          if (s.slot == slot_last) begin
            next_s.slot = 8'h00;
            next_s.sym = s.sym + 2'd1;
            if (code != tx_enc_pkg::CODE_ONE_OF_4
                || s.sym == tx_enc_pkg::SYM_LAST_4) begin
              next_s.state = end_state;
            end
          end
        end
      end
      tx_enc_pkg::ST_GAP: begin
        if (bit_end) begin
          next_s.state = tx_enc_pkg::ST_NEXT;
        end
      end
      default: next_s.state = tx_enc_pkg::ST_IDLE;
    endcase
    next_s.ready = next_s.state == tx_enc_pkg::ST_IDLE
                || next_s.state == tx_enc_pkg::ST_NEXT;
    next_s.busy = next_s.state != tx_enc_pkg::ST_IDLE;
    next_s.frame = next_s.busy && next_s.state != tx_enc_pkg::ST_GAP
                && !(next_s.state == tx_enc_pkg::ST_NEXT && frame_step);
    next_s.env = run ? shaped : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.frame_opt <= tx_enc_pkg::FRAME_OPT_RESET;
      s.bit_framing <= tx_enc_pkg::REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign tx_ready = s.ready;
  assign tx_envelope = s.env;
  assign tx_frame = s.frame;
  assign tx_busy = s.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence start_done_s;
    s.state == tx_enc_pkg::ST_START && adv;
  endsequence
  sequence take_plain_s;
    accept && !start_enable && !slot_code;
  endsequence
  sequence last_stop_s;
    s.state == tx_enc_pkg::ST_STOP && adv && frame_step && !s.last;
  endsequence

  bit_order_a: assert property (
    s.state == tx_enc_pkg::ST_DATA && s.idx == 3'd0 |->
      cur_bit == (high_order ? s.byte_buf[7] : s.byte_buf[0]))
    else $error("first data bit has wrong order");
  parity_kind_a: assert property (
    s.state == tx_enc_pkg::ST_PARITY |->
      (^{s.byte_buf, cur_bit}) == parity_odd)
    else $error("parity bit has wrong kind");
  stop_level_a: assert property (
    s.state == tx_enc_pkg::ST_STOP && !is_pie && !is_rz
      && !s.data_mod[tx_enc_pkg::MILLER_POS] |-> pseudo == stop_level)
    else $error("stop bit level wrong");
  start_level_a: assert property (
    s.state == tx_enc_pkg::ST_START |-> cur_bit == start_level)
    else $error("start bit level wrong");
  start_skip_a: assert property (
    take_plain_s |=> s.state == tx_enc_pkg::ST_DATA && s.idx == 3'd0)
    else $error("start bit sent while disabled");
  rz_position_a: assert property (
    bit_state && is_rz && pseudo |-> quarter == code[1:0] && cur_bit)
    else $error("return-to-zero pulse misplaced");
  zero_silent_a: assert property (
    s.state == tx_enc_pkg::ST_SLOTS && s.byte_buf == 8'h00
      && code == tx_enc_pkg::CODE_256_ZERO_NONE |-> !pseudo)
    else $error("zero byte pulsed in silent mode");
  zero_last_a: assert property (
    s.state == tx_enc_pkg::ST_SLOTS && s.byte_buf == 8'h00
      && code == tx_enc_pkg::CODE_256_ZERO_LAST |->
      pseudo == (s.slot == tx_enc_pkg::SLOT_LAST_256))
    else $error("zero byte pulse not in last slot");
  frame_order_a: assert property (
    start_done_s |=> s.state == tx_enc_pkg::ST_DATA ##0 s.idx == 3'd0)
    else $error("data did not follow start bit");
  frame_gap_a: assert property (
    last_stop_s |=> !tx_frame && s.state == tx_enc_pkg::ST_GAP)
    else $error("byte not closed in own frame");
  reg_read_a: assert property (
    rd && addr == tx_enc_pkg::ADDR_DATA_CODING |=>
      rdata == $past(s.data_coding))
    else $error("register read data wrong");
endmodule : tx_bit_framing_encoder

/* File: hw/tx_enc_pkg.sv */
package tx_enc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_BIT_FRAMING = 8'h48;
  localparam logic [7:0] ADDR_DATA_CODING = 8'h4a;
  localparam logic [7:0] ADDR_DATA_MOD = 8'h4b;
  localparam logic [7:0] ADDR_FRAME_OPT = 8'h4c;
  localparam logic [7:0] ADDR_STATUS = 8'h4d;
  // reset values and writable masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BIT_FRAMING_MASK = 8'hab;
  localparam logic [7:0] FRAME_OPT_MASK = 8'h03;
  localparam logic [7:0] FRAME_OPT_RESET = 8'h03;
  // bit framing fields
  localparam int HIGH_ORDER_POS = 7;
  localparam int PARITY_ODD_POS = 5;
  localparam int STOP_LEVEL_POS = 3;
  localparam int START_LEVEL_POS = 1;
  localparam int START_ENABLE_POS = 0;
  // data coding fields
  localparam int CODE_SEL_POS = 4;
  localparam int SUBCARRIER_POS = 3;
  localparam int BIT_RATE_POS = 0;
  // data modulation fields
  localparam int FRAME_STEP_POS = 7;
  localparam int MILLER_POS = 6;
  localparam int PULSE_KIND_POS = 4;
  localparam int INVERT_POS = 3;
  localparam int ENV_KIND_POS = 0;
  // frame option and status fields
  localparam int PARITY_EN_POS = 0;
  localparam int STOP_EN_POS = 1;
  localparam int BUSY_POS = 0;
  localparam int FRAME_POS = 1;
  localparam int READY_POS = 2;
  // code select values
  localparam logic [3:0] CODE_ONE_OF_4 = 4'h8;
  localparam logic [3:0] CODE_256 = 4'h9;
  localparam logic [3:0] CODE_256_ZERO_NONE = 4'ha;
  localparam logic [3:0] CODE_256_ZERO_LAST = 4'hb;
  localparam logic [3:0] CODE_PIE = 4'hc;
  localparam logic [3:0] CODE_RZ_FIRST = 4'h4;
  localparam logic [3:0] CODE_RZ_LAST = 4'h7;
  // pulse and envelope kinds
  localparam logic [1:0] PULSE_NONE = 2'h0;
  localparam logic [1:0] PULSE_START = 2'h1;
  localparam logic [1:0] PULSE_HALF = 2'h2;
  localparam logic [1:0] PULSE_QUARTER3 = 2'h3;
  localparam logic [2:0] ENV_DIRECT = 3'h0;
  localparam logic [2:0] ENV_MANCH = 3'h1;
  localparam logic [2:0] ENV_MANCH_SC = 3'h2;
  localparam logic [2:0] ENV_BPSK = 3'h3;
  // slot and unit counts
  localparam logic [7:0] SLOT_LAST_4 = 8'h03;
  localparam logic [7:0] SLOT_LAST_256 = 8'hff;
  localparam logic [1:0] SYM_LAST_4 = 2'h3;
  localparam logic [1:0] PIE_ZERO_LAST = 2'h1;
  localparam logic [1:0] PIE_ONE_LAST = 2'h3;
  // timing
  localparam int CLK_KHZ = 50000;
  localparam int RATE_26_KHZ = 26;
  localparam int RATE_53_KHZ = 53;
  localparam int RATE_106_KHZ = 106;
  localparam int RATE_212_KHZ = 212;
  localparam int RATE_424_KHZ = 424;
  localparam int RATE_848_KHZ = 848;
  localparam int SC_424_KHZ = 424;
  localparam int SC_848_KHZ = 848;
  localparam logic [9:0] QUARTER_26 = 10'(CLK_KHZ / (4 * RATE_26_KHZ));
  localparam logic [9:0] QUARTER_53 = 10'(CLK_KHZ / (4 * RATE_53_KHZ));
  localparam logic [9:0] QUARTER_106 = 10'(CLK_KHZ / (4 * RATE_106_KHZ));
  localparam logic [9:0] QUARTER_212 = 10'(CLK_KHZ / (4 * RATE_212_KHZ));
  localparam logic [9:0] QUARTER_424 = 10'(CLK_KHZ / (4 * RATE_424_KHZ));
  localparam logic [9:0] QUARTER_848 = 10'(CLK_KHZ / (4 * RATE_848_KHZ));
  localparam logic [6:0] SC_HALF_424 = 7'(CLK_KHZ / (2 * SC_424_KHZ));
  localparam logic [6:0] SC_HALF_848 = 7'(CLK_KHZ / (2 * SC_848_KHZ));

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_SLOTS, ST_GAP, ST_NEXT
  } tx_state_t;
endpackage : tx_enc_pkg

/* File: testbench/card_listener.sv */
`timescale 1ns/1ps
// far-side model: counts envelope pulses within a frame
module card_listener (
  input wire logic clk,
  input wire logic reset,
  input wire logic envelope,
  input wire logic frame,
  output logic [15:0] rises,
  output logic [15:0] first_at
);
  logic [15:0] cnt;
  logic frame_q;
  logic env_q;
  always_ff @(posedge clk) begin
    frame_q <= frame;
    env_q <= envelope;
    if (reset || (frame && !frame_q)) begin
      cnt <= 16'h0000;
      rises <= 16'h0000;
      first_at <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
      if (envelope && !env_q) begin
        rises <= rises + 16'h0001;
        if (rises == 16'h0000) first_at <= cnt;
      end
    end
  end
endmodule : card_listener

/* File: testbench/tx_bit_framing_encoder_tb.sv */
`timescale 1ns/1ps
module tx_bit_framing_encoder_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rdata;
  logic tx_ready, tx_envelope, tx_frame, tx_busy;
  logic [15:0] rises, first_at, got;
  int error_cnt = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  tx_bit_framing_encoder dut (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_envelope(tx_envelope), .tx_frame(tx_frame), .tx_busy(tx_busy));
  card_listener card (.clk(clk), .reset(reset), .envelope(tx_envelope),
    .frame(tx_frame), .rises(rises), .first_at(first_at));
  task automatic tally_and_finish();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [15:0] e, s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : rd_chk
  task automatic send(input logic [7:0] b, input int nb, input logic lst);
    int i;
    got = 16'h0000;
    @(posedge clk);
    tx_data <= b;
    tx_last <= lst;
    tx_valid <= 1'b1;
    i = 0;
    @(negedge clk);
    while (tx_ready !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (tx_ready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    @(posedge clk);
    tx_valid <= 1'b0;
    @(negedge clk);
    chk("busy", 16'h0001, {15'h0000, tx_busy});
    chk("ready_low", 16'h0000, {15'h0000, tx_ready});
    for (i = 0; i < nb; i++) begin
      repeat (i == 0 ? 28 : 56) @(negedge clk);
      got[i] = tx_envelope;
    end
    i = 0;
    while (tx_ready !== 1'b1 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    if (tx_ready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    chk("frame_end", 16'h0000, {15'h0000, tx_frame});
    chk("busy_end", {15'h0000, !lst}, {15'h0000, tx_busy});
  endtask : send
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd_chk(8'h48, 8'h00);
    rd_chk(8'h4c, 8'h03);
    wr_reg(8'h48, 8'hff);
    rd_chk(8'h48, 8'hab);
    wr_reg(8'h50, 8'h77);
    rd_chk(8'h50, 8'h00);
    rd_chk(8'h4d, 8'h04);
    wr_reg(8'h4a, 8'h07);
    wr_reg(8'h48, 8'h23);
    send(8'h35, 11, 1);
    chk("lsb_odd_start", 16'h026b, got);
    wr_reg(8'h48, 8'h88);
    send(8'ha1, 10, 1);
    chk("msb_even_stop", 16'h0385, got);
    wr_reg(8'h4a, 8'h97);
    send(8'h02, 0, 1);
    chk("slot_of_two", 16'h0002, first_at / 16'd56);
    chk("pulses_two", 16'h0001, rises);
    wr_reg(8'h4a, 8'ha7);
    send(8'h00, 0, 1);
    chk("zero_no_pulse", 16'h0000, rises);
    wr_reg(8'h4a, 8'hb7);
    send(8'h00, 0, 1);
    chk("zero_last_slot", 16'h00ff, first_at / 16'd56);
    wr_reg(8'h4a, 8'h1e);
    send(8'h40, 0, 1);
    chk("rate_424_first", 16'h0074, first_at);
    chk("rate_424_pulses", 16'h0002, rises);
    wr_reg(8'h4a, 8'h67);
    send(8'h40, 0, 1);
    chk("rz_third_first", 16'h0054, first_at);
    chk("rz_third_pulses", 16'h0003, rises);
    wr_reg(8'h4a, 8'h87);
    send(8'he4, 0, 1);
    chk("quad_first", 16'h00a8, first_at);
    chk("quad_pulses", 16'h0004, rises);
    wr_reg(8'h4a, 8'hc7);
    send(8'h80, 0, 1);
    chk("pie_first", 16'h00a8, first_at);
    chk("pie_pulses", 16'h000a, rises);
    wr_reg(8'h4a, 8'h07);
    wr_reg(8'h4b, 8'h20);
    send(8'h40, 0, 1);
    chk("half_first", 16'h0054, first_at);
    chk("half_pulses", 16'h0003, rises);
    wr_reg(8'h4b, 8'h01);
    send(8'h00, 0, 1);
    chk("manch_first", 16'h001c, first_at);
    chk("manch_pulses", 16'h0009, rises);
    wr_reg(8'h4b, 8'h08);
    send(8'h40, 10, 1);
    chk("inverted", 16'h00fd, got);
    wr_reg(8'h4b, 8'h50);
    send(8'h00, 0, 1);
    chk("miller_pulses", 16'h000a, rises);
    wr_reg(8'h4b, 8'h80);
    send(8'h40, 0, 0);
    send(8'h40, 0, 1);
    chk("step_first", 16'h0038, first_at);
    chk("step_pulses", 16'h0002, rises);
    tally_and_finish();
  end
endmodule : tx_bit_framing_encoder_tb
